/* File: verilog/seom_pkg.sv */
package seom_pkg;
  localparam int seom_pins = 12;
  localparam int seom_chans = 16;
  localparam int seom_kinds = 4;
  localparam int seom_dly_w = 16;
  localparam logic [7:0] seom_setup_code = 8'hd2;
  localparam int seom_func_lsb = 0;
  localparam int seom_pol_bit = 6;
  localparam int seom_drive_bit = 7;
  localparam int seom_mask_lsb = 16;
  localparam logic [31:0] seom_setup_reset = 32'h0000_0000;
  localparam logic [31:0] seom_setup_wmask = 32'hffff_00c7;
  localparam logic [3:0] seom_fault_line_two_page = 4'ha;
  localparam logic [3:0] seom_order_page = 4'hb;

  typedef enum logic [2:0] {
    seom_fn_supply = 3'h0,
    seom_fn_force_on = 3'h1,
    seom_fn_force_off = 3'h2,
    seom_fn_all_good = 3'h3,
    seom_fn_any_alarm = 3'h4,
    seom_fn_special = 3'h5
  } seom_func_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [3:0] page;
    logic [31:0] wdata;
  } seom_cmd_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] rdata;
  } seom_rsp_type;
endpackage

/* File: verilog/seom_cfg_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module seom_cfg_mem
#(
  parameter int DEPTH = 12,
  parameter int W = 32,
  parameter logic [W-1:0] RESET_WORD = '0
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [W-1:0] wdata,
  // registered read port
  input wire logic re,
  input wire logic [3:0] raddr,
  output logic [W-1:0] rdata,
  // every word at once for the pin logic
  output logic [DEPTH-1:0][W-1:0] words
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] word;
    logic [W-1:0] rdata;
  } seom_mem_state_type;

  seom_mem_state_type st;
  seom_mem_state_type next_st;

  always_comb
  begin
    next_st = st;
    if (we && (int'(waddr) < DEPTH))
    begin
      next_st.word[waddr] = wdata;
    end
    // misses read zero so the response never leaks stale data
    next_st.rdata = '0;
    if (re && (int'(raddr) < DEPTH))
    begin
      next_st.rdata = st.word[raddr];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.word <= {DEPTH{RESET_WORD}};
      st.rdata <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign words = st.word;
endmodule // seom_cfg_mem
`default_nettype wire

/* File: verilog/seom_delay_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module seom_delay_filter
#(
  parameter int DLY_W = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // level in, delays in cycles
  input wire logic din,
  input wire logic [DLY_W-1:0] on_delay,
  input wire logic [DLY_W-1:0] off_delay,
  // filtered level
  output logic dout
);
  typedef struct packed {
    logic out;
    logic last;
    logic [DLY_W-1:0] cnt;
  } seom_flt_state_type;

  seom_flt_state_type st;
  seom_flt_state_type next_st;
  logic [DLY_W-1:0] need;

  always_comb
  begin
    next_st = st;
    need = din ? on_delay : off_delay;
    if (din != st.last)
    begin
      next_st.last = din;
      next_st.cnt = '0;
    end
    else if (din != st.out)
    begin
      // count saturates at the delay, so no wrap can fake a timeout
      if (st.cnt >= need)
      begin
        next_st.out = din;
      end
      else
      begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.out;

  sequence s_input_moved;
    $changed(din);
  endsequence

  sequence s_output_moved;
    $changed(dout);
  endsequence

  property p_restart;
    @(posedge core_clk) disable iff (!reset_n)
    s_input_moved |=> $stable(dout);
  endproperty

  property p_waited;
    @(posedge core_clk) disable iff (!reset_n)
    s_output_moved |-> ($past(st.cnt) >= $past(need)) && ($past(din) == dout);
  endproperty

  a_restart_wait: assert property (p_restart) else $error("output moved on input change");
  a_full_delay: assert property (p_waited) else $error("output moved before delay");
endmodule // seom_delay_filter
`default_nettype wire

/* File: verilog/seom_top.sv */
`timescale 1ns/1ps
`default_nettype none
module seom_top
#(
  parameter int PINS = 12,
  parameter int CHANS = 16,
  parameter int DLY_W = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // command port, one setup word per page
  input wire seom_pkg::seom_cmd_type cmd,
  output seom_pkg::seom_rsp_type rsp,
  // sequencer supply enables per pin
  input wire logic [PINS-1:0] seq_enable,
  // per channel goodness sources
  input wire logic [CHANS-1:0] rail_good_flag,
  input wire logic [CHANS-1:0] general_input_flag,
  input wire logic [CHANS-1:0] use_general_input,
  // per channel alarms and alarm kind chosen by fault reaction setup
  input wire logic [CHANS-1:0][seom_pkg::seom_kinds-1:0] alarm_kind_flags,
  input wire logic [CHANS-1:0][1:0] alarm_kind_sel,
  // special function sources
  input wire logic fault_line_two,
  input wire logic ordering_special_function,
  // per pin delays in cycles
  input wire logic [PINS-1:0][DLY_W-1:0] on_delay,
  input wire logic [PINS-1:0][DLY_W-1:0] off_delay,
  // output pins
  output logic [PINS-1:0] supply_enable_output_pin_o,
  output logic [PINS-1:0] supply_enable_output_pin_oe_n
);
  import seom_pkg::*;

  typedef struct packed {
    logic [CHANS-1:0] gpi_meta;
    logic [CHANS-1:0] gpi_sync;
    logic rsp_valid;
    logic rsp_hit;
    logic [PINS-1:0] pin_o;
    logic [PINS-1:0] pin_oe_n;
  } seom_top_state_type;

  seom_top_state_type st;
  seom_top_state_type next_st;

  logic hit;
  logic mem_we;
  logic mem_re;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [PINS-1:0][31:0] cfg;
  logic [CHANS-1:0] goodness;
  logic [CHANS-1:0] alarm_sel;
  logic [PINS-1:0] func_lvl;
  logic [PINS-1:0] filt;

  function automatic logic [2:0] seom_func_of(input logic [31:0] w);
    seom_func_of = w[seom_func_lsb +: 3];
  endfunction

  function automatic logic [CHANS-1:0] seom_mask_of(input logic [31:0] w);
    seom_mask_of = w[seom_mask_lsb +: CHANS];
  endfunction

  // pin function before delay filter and polarity
  function automatic logic seom_pin_func
  (
    input logic [31:0] w,
    input int idx,
    input logic seq_en,
    input logic [CHANS-1:0] good,
    input logic [CHANS-1:0] alarm
  );
    logic [CHANS-1:0] mask;
    logic [2:0] fn;
    mask = seom_mask_of(w);
    fn = seom_func_of(w);
    seom_pin_func = 1'b0;
    unique case (fn)
      seom_fn_supply:
      begin
        seom_pin_func = seq_en;
      end
      seom_fn_force_on:
      begin
        seom_pin_func = 1'b1;
      end
      seom_fn_force_off:
      begin
        seom_pin_func = 1'b0;
      end
      seom_fn_all_good:
      begin
        seom_pin_func = &(good | ~mask);
      end
      seom_fn_any_alarm:
      begin
        seom_pin_func = |(alarm & mask);
      end
      seom_fn_special:
      begin
        // only two pins own a special function
        if (idx == int'(seom_fault_line_two_page))
        begin
          seom_pin_func = fault_line_two;
        end
        else if (idx == int'(seom_order_page))
        begin
          seom_pin_func = ordering_special_function;
        end
      end
      default:
      begin
        // reserved codes hold the pin deasserted
        seom_pin_func = 1'b0;
      end
    endcase
  endfunction

  // command decode, one word per page
  always_comb
  begin
    hit = cmd.valid && (cmd.code == seom_setup_code) && (int'(cmd.page) < PINS);
    mem_we = hit && cmd.write;
    mem_re = hit && !cmd.write;
    mem_wdata = cmd.wdata & seom_setup_wmask;
  end

  seom_cfg_mem
  #(
    .DEPTH(PINS),
    .W(32),
    .RESET_WORD(seom_setup_reset)
  )
  u_cfg_mem
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .we(mem_we),
    .waddr(cmd.page),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(cmd.page),
    .rdata(mem_rdata),
    .words(cfg)
  );

  // per channel goodness and alarm of the configured kind
  always_comb
  begin
    for (int c = 0; c < CHANS; c++)
    begin
      goodness[c] = use_general_input[c] ? st.gpi_sync[c] : rail_good_flag[c];
      alarm_sel[c] = alarm_kind_flags[c][alarm_kind_sel[c]];
    end
  end

  always_comb
  begin
    for (int p = 0; p < PINS; p++)
    begin
      func_lvl[p] = seom_pin_func(cfg[p], p, seq_enable[p], goodness, alarm_sel);
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++)
    begin : g_pin
      seom_delay_filter
      #(
        .DLY_W(DLY_W)
      )
      u_filter
      (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .din(func_lvl[gp]),
        .on_delay(on_delay[gp]),
        .off_delay(off_delay[gp]),
        .dout(filt[gp])
      );
    end
  endgenerate

  always_comb
  begin
    logic lvl;
    lvl = 1'b0;
    next_st = st;
    // general inputs come from pins, so two flops first
    next_st.gpi_meta = general_input_flag;
    next_st.gpi_sync = st.gpi_meta;
    next_st.rsp_valid = cmd.valid;
    next_st.rsp_hit = hit;
    for (int p = 0; p < PINS; p++)
    begin
      lvl = cfg[p][seom_pol_bit] ~^ filt[p];
      if (cfg[p][seom_drive_bit])
      begin
        next_st.pin_o[p] = 1'b0;
        next_st.pin_oe_n[p] = lvl;
      end
      else
      begin
        next_st.pin_o[p] = lvl;
        next_st.pin_oe_n[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // reset word is active low push-pull, so pins sit high
      st.gpi_meta <= '0;
      st.gpi_sync <= '0;
      st.rsp_valid <= 1'b0;
      st.rsp_hit <= 1'b0;
      st.pin_o <= '1;
      st.pin_oe_n <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rsp = '{valid: st.rsp_valid,
    hit: st.rsp_hit,
    rdata: mem_rdata};
  assign supply_enable_output_pin_o = st.pin_o;
  assign supply_enable_output_pin_oe_n = st.pin_oe_n;

  // checks on the response path
  sequence s_read_taken;
    cmd.valid && !cmd.write && hit;
  endsequence

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!reset_n)
    rsp.valid |-> (rsp.rdata[15:8] == 8'h00) && (rsp.rdata[5:3] == 3'h0);
  endproperty

  property p_miss_zero;
    @(posedge core_clk) disable iff (!reset_n)
    (cmd.valid && !hit) |=> rsp.valid && !rsp.hit && (rsp.rdata == 32'h0000_0000);
  endproperty

  property p_read_back;
    @(posedge core_clk) disable iff (!reset_n)
    s_read_taken |=> rsp.valid && rsp.hit && (rsp.rdata == $past(cfg[cmd.page]));
  endproperty

  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
  a_miss_reads: assert property (p_miss_zero) else $error("unmapped access answered");
  a_read_back: assert property (p_read_back) else $error("read data mismatch");

  generate
    for (gp = 0; gp < PINS; gp++)
    begin : g_chk
      property p_force(logic [2:0] fn, logic v);
        @(posedge core_clk) disable iff (!reset_n)
        (seom_func_of(cfg[gp]) == fn) |-> (func_lvl[gp] == v);
      endproperty

      property p_od;
        @(posedge core_clk) disable iff (!reset_n)
        $past(cfg[gp][seom_drive_bit])
          |-> !supply_enable_output_pin_o[gp]
          && (supply_enable_output_pin_oe_n[gp] == $past(cfg[gp][seom_pol_bit] ~^ filt[gp]));
      endproperty

      property p_pp;
        @(posedge core_clk) disable iff (!reset_n)
        !$past(cfg[gp][seom_drive_bit])
          |-> !supply_enable_output_pin_oe_n[gp]
          && (supply_enable_output_pin_o[gp] == $past(cfg[gp][seom_pol_bit] ~^ filt[gp]));
      endproperty

      a_supply_follow: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (seom_func_of(cfg[gp]) == seom_fn_supply) |-> (func_lvl[gp] == seq_enable[gp])
      ) else $error("supply enable not followed");
      a_force_on: assert property (p_force(seom_fn_force_on, 1'b1))
        else $error("forced assert lost");
      a_force_off: assert property (p_force(seom_fn_force_off, 1'b0))
        else $error("forced deassert lost");
      a_all_good: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (seom_func_of(cfg[gp]) == seom_fn_all_good)
          |-> (func_lvl[gp] == &(goodness | ~seom_mask_of(cfg[gp])))
      ) else $error("good combine wrong");
      a_any_alarm: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (seom_func_of(cfg[gp]) == seom_fn_any_alarm)
          |-> (func_lvl[gp] == |(alarm_sel & seom_mask_of(cfg[gp])))
      ) else $error("alarm combine wrong");
      a_alarm_blocked: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ((seom_func_of(cfg[gp]) == seom_fn_any_alarm) && ((alarm_sel & seom_mask_of(cfg[gp])) == '0))
          |-> !func_lvl[gp]
      ) else $error("masked alarm passed");
      a_mask_ignored: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ((seom_func_of(cfg[gp]) <= seom_fn_force_off) && $changed(seom_mask_of(cfg[gp]))
          && $stable(seom_func_of(cfg[gp])) && $stable(seq_enable[gp]))
          |-> $stable(func_lvl[gp])
      ) else $error("mask used outside its functions");
      if ((gp != int'(seom_fault_line_two_page)) && (gp != int'(seom_order_page)))
      begin : g_nospecial
        a_no_special: assert property (
          @(posedge core_clk) disable iff (!reset_n)
          (seom_func_of(cfg[gp]) == seom_fn_special) |-> !func_lvl[gp]
        ) else $error("special function on plain pin");
      end
      a_open_drain: assert property (p_od) else $error("open drain drove high");
      a_push_pull: assert property (p_pp) else $error("push pull level wrong");
    end
  endgenerate
endmodule // seom_top
`default_nettype wire

/* File: bench/seom_pin_load.sv */
`timescale 1ns/1ps
`default_nettype none
module seom_pin_load
#(
  parameter int PINS = 12
)
(
  // pin drivers from the block
  input wire logic [PINS-1:0] pin_o,
  input wire logic [PINS-1:0] pin_oe_n,
  // wire level seen by the loads
  output logic [PINS-1:0] pin_level
);
  // board pull-up: a released open-drain pin reads high, never a stale value
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
      pin_level[i] = pin_oe_n[i] ? 1'b1 : pin_o[i];
  end
endmodule // seom_pin_load
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import seom_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  seom_cmd_type cmd;
  seom_rsp_type rsp;
  logic [11:0] seq_enable;
  logic [15:0] rail_good_flag, general_input_flag, use_general_input;
  logic [15:0][3:0] alarm_kind_flags;
  logic [15:0][1:0] alarm_kind_sel;
  logic fault_line_two, ordering_special_function;
  logic [11:0][15:0] on_delay, off_delay;
  logic [11:0] pin_o, pin_oe_n, pin_level;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 core_clk = ~core_clk;

  seom_top u_seom_top (.core_clk(core_clk), .reset_n(reset_n), .cmd(cmd), .rsp(rsp),
    .seq_enable(seq_enable), .rail_good_flag(rail_good_flag),
    .general_input_flag(general_input_flag), .use_general_input(use_general_input),
    .alarm_kind_flags(alarm_kind_flags), .alarm_kind_sel(alarm_kind_sel),
    .fault_line_two(fault_line_two), .ordering_special_function(ordering_special_function),
    .on_delay(on_delay), .off_delay(off_delay), .supply_enable_output_pin_o(pin_o),
    .supply_enable_output_pin_oe_n(pin_oe_n));
  seom_pin_load u_seom_pin_load (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] code, input logic [3:0] page,
    input logic [31:0] wd, output logic [31:0] rd, output logic hit);
    @(negedge core_clk);
    cmd = '{valid: 1'b1, write: wr, code: code, page: page, wdata: wd};
    @(negedge core_clk);
    cmd.valid = 1'b0;
    for (int i = 0; i < 3 && rsp.valid !== 1'b1; i++)
      @(negedge core_clk);
    chk({31'h0, rsp.valid}, 32'h1);
    rd = rsp.rdata;
    hit = rsp.hit;
  endtask

  task automatic put(input int p, input logic [31:0] wd);
    logic [31:0] rd;
    logic hit;
    logic [11:0] run;
    // sequencer held off while a setup word changes
    @(negedge core_clk);
    run = seq_enable;
    seq_enable = '0;
    access(1'b1, seom_setup_code, p[3:0], wd, rd, hit);
    seq_enable = run;
    chk({31'h0, hit}, 32'h1);
  endtask

  task automatic pin_is(input int p, input logic lvl);
    chk({31'h0, pin_level[p]}, {31'h0, lvl});
  endtask

  // pin asserted for each function with input set s
  function automatic logic asserted(input logic [2:0] f, input int p, input logic s);
    case (f)
      3'h0: return s;
      3'h1: return 1'b1;
      3'h3: return s;
      3'h4: return ~s;
      3'h5: return (p == 10) ? s : ((p == 11) ? ~s : 1'b0);
      default: return 1'b0;
    endcase
  endfunction

  task automatic set_inputs(input logic s);
    @(negedge core_clk);
    // enables stand for channels already set to sequence mode
    seq_enable = {12{s}};
    // ch1 good only through its general input; ch5 fails in set 0
    rail_good_flag = s ? 16'hfffd : 16'hffdd;
    general_input_flag = 16'h0002;
    use_general_input = 16'h0002;
    alarm_kind_sel = '0;
    alarm_kind_sel[2] = 2'h2;
    alarm_kind_flags = '0;
    // set 1: ch2 has only unselected kinds, ch7 is not in the mask
    alarm_kind_flags[2] = s ? 4'hb : 4'h4;
    alarm_kind_flags[7] = s ? 4'hf : 4'h0;
    fault_line_two = s;
    ordering_special_function = ~s;
  endtask

  task automatic t_reset_regs;
    logic [31:0] rd;
    logic hit;
    chk({20'h0, pin_o}, 32'h0000_0fff);
    chk({20'h0, pin_oe_n}, 32'h0);
    for (int p = 0; p < 12; p++)
    begin
      access(1'b0, seom_setup_code, p[3:0], 32'h0, rd, hit);
      chk(rd, seom_setup_reset);
      put(p, 32'hffff_ffff);
      access(1'b0, seom_setup_code, p[3:0], 32'h0, rd, hit);
      chk(rd, 32'hffff_00c7);
    end
    access(1'b1, seom_setup_code, 4'hc, 32'h0000_0041, rd, hit);
    access(1'b0, seom_setup_code, 4'hc, 32'h0, rd, hit);
    chk(rd | {31'h0, hit}, 32'h0);
    access(1'b0, 8'hd3, 4'h0, 32'h0, rd, hit);
    chk(rd | {31'h0, hit}, 32'h0);
  endtask

  task automatic t_modes;
    int pins[3] = '{3, 10, 11};
    int q;
    logic e;
    for (int s = 0; s < 2; s++)
    begin
      set_inputs(s[0]);
      for (int f = 0; f < 8; f++)
        for (int k = 0; k < 3; k++)
        begin
          q = pins[k];
          e = asserted(f[2:0], q, s[0]);
          put(q, {16'h0026, 8'h00, 8'h40 | f[7:0]});
          // write lands, filter two edges, pin register one, plus input sync
          repeat (8) @(negedge core_clk);
          pin_is(q, e);
          chk({30'h0, pin_oe_n[q], pin_o[q]}, {31'h0, e});
        end
    end
  endtask

  task automatic t_drive;
    for (int c = 0; c < 4; c++)
    begin
      put(4, {24'h0, c[1], c[0], 6'h01});
      repeat (8) @(negedge core_clk);
      pin_is(4, c[0]);
      chk({31'h0, pin_oe_n[4]}, {31'h0, c[1] & c[0]});
      chk({31'h0, pin_o[4]}, {31'h0, ~c[1] & c[0]});
    end
  endtask

  task automatic t_delay;
    @(negedge core_clk);
    on_delay[5] = 16'h0006;
    off_delay[5] = 16'h0003;
    rail_good_flag[0] = 1'b0;
    put(5, 32'h0001_0043);
    repeat (20) @(negedge core_clk);
    pin_is(5, 1'b0);
    rail_good_flag[0] = 1'b1;
    repeat (5) @(negedge core_clk);
    pin_is(5, 1'b0);
    repeat (6) @(negedge core_clk);
    pin_is(5, 1'b1);
    // low pulse shorter than the off wait must be swallowed
    rail_good_flag[0] = 1'b0;
    repeat (2) @(negedge core_clk);
    rail_good_flag[0] = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge core_clk);
      pin_is(5, 1'b1);
    end
    rail_good_flag[0] = 1'b0;
    repeat (10) @(negedge core_clk);
    pin_is(5, 1'b0);
    // a blip in mid-wait must restart the on count
    rail_good_flag[0] = 1'b1;
    repeat (4) @(negedge core_clk);
    rail_good_flag[0] = 1'b0;
    @(negedge core_clk);
    rail_good_flag[0] = 1'b1;
    repeat (5) @(negedge core_clk);
    pin_is(5, 1'b0);
    repeat (6) @(negedge core_clk);
    pin_is(5, 1'b1);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    cmd = '0;
    seq_enable = '0;
    rail_good_flag = '0;
    general_input_flag = '0;
    use_general_input = '0;
    alarm_kind_flags = '0;
    alarm_kind_sel = '0;
    fault_line_two = 1'b0;
    ordering_special_function = 1'b0;
    on_delay = '0;
    off_delay = '0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    t_reset_regs;
    t_modes;
    t_drive;
    t_delay;
    wrap_up;
  end

  // whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
